// >>> rtl/slb_prbs_bist.sv
`timescale 1ns/100ps
`default_nettype none
`include "slb_regs.svh"
module slb_prbs_bist
   import slb_pkg::*;
#(
   parameter int unsigned PASS_SYMBOLS = 44000000   // checked symbols before pass
)(
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire logic                 self_test_enable,
   input  wire logic [31:0]          parallel_data_in,
   input  wire logic                 in_valid,
   output logic                      in_ready,
   output logic [`SLB_SYM_W-1:0]     tx_lane0,
   output logic [`SLB_SYM_W-1:0]     tx_lane1,
   output logic                      tx_valid,
   input  wire logic                 tx_ready,
   output logic                      self_test_active,
   input  wire logic [`SLB_SYM_W-1:0] rx_lane0,
   input  wire logic [`SLB_SYM_W-1:0] rx_lane1,
   input  wire logic                 rx_lock,
   output logic [31:0]               recovered_data_out,
   output logic                      out_valid,
   output logic                      check_active
);

   localparam int SW = `SLB_SYM_W;
   localparam int CW = `SLB_SYM_CNT_W;
   localparam logic [CW-1:0] PASS_LAST = CW'(PASS_SYMBOLS - 1);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [2:0]                     sync;   // pin synchroniser, [0] first
      logic                           lvl;    // agreed pin level
      logic [2:0]                     run;    // cycles level differs from mode
      logic                           test;   // serializer test mode
      logic [1:0][`SLB_PRBS_W-1:0]    gen;    // generator history per lane
      logic [1:0][2*SW-1:0]           mem;    // two-entry transmit buffer
      logic [1:0]                     cnt;    // buffer fill
      logic                           rp;     // read slot
      logic                           wp;     // write slot
      logic [1:0][SW-1:0]             prev;   // last received word per lane
      slb_lane_type [1:0]             lane;   // checker state per lane
      logic [1:0][2:0]                det;    // clean symbol run
      logic [1:0][6:0]                lose;   // failing symbol run
      logic [1:0][CW-1:0]             sym;    // checked symbols
      logic [1:0]                     pass;   // sticky pass flags
      logic [1:0][6:0]                err;    // saturating error counts
      logic [31:0]                    dout;   // registered parallel output
      logic                           dvalid; // registered lock
   } slb_state_type;

   slb_state_type st_q;   // registered state
   slb_state_type st_d;   // next state

   // ----------------------------------------------------------------------
   // pattern helpers
   // ----------------------------------------------------------------------
   // one cycle of generator output, first sent bit in bit 0
   function automatic logic [SW+`SLB_PRBS_W-1:0] prbs_step(input logic [6:0] h_in);
      logic [6:0]    h;
      logic [SW-1:0] w;
      h = h_in;
      w = '0;
      for (int i = 0; i < SW; i++) begin
         w[i] = h[5] ^ h[6];                    // RULE_17
         h    = {h[5:0], w[i]};
      end
      return {h, w};
   endfunction : prbs_step

   // number of set bits in a mismatch word
   function automatic logic [4:0] ones(input logic [SW-1:0] v);
      logic [4:0] n;
      n = '0;
      for (int i = 0; i < SW; i++) begin
         n = n + 5'(v[i]);
      end
      return n;
   endfunction : ones

   logic [SW-1:0] rx_w  [2];   // received word per lane
   logic [SW-1:0] gen_w [2];   // generated word per lane
   logic [6:0]    gen_h [2];   // generator history after the word
   logic [SW-1:0] mism  [2];   // bits that break the recurrence
   logic [4:0]    nerr  [2];   // mismatch count this symbol

   assign rx_w[0] = rx_lane0;
   assign rx_w[1] = rx_lane1;

   // each lane has its own generator and its own checker
   for (genvar l = 0; l < 2; l++) begin : g_lane
      logic [2*SW-1:0] strm;   // previous word then current, oldest in bit 0
      assign {gen_h[l], gen_w[l]} = prbs_step(st_q.gen[l]);   // RULE_03
      assign strm    = {rx_w[l], st_q.prev[l]};
      // self-seeding: expected bits come from the received stream itself
      assign mism[l] = rx_w[l] ^ (strm[`SLB_TAP_NEAR+SW-1:`SLB_TAP_NEAR]
                                ^ strm[`SLB_TAP_FAR+SW-1:`SLB_TAP_FAR]);   // RULE_06 RULE_17
      assign nerr[l] = ones(mism[l]);
   end

   logic            room;       // buffer can take a word
   logic            push;       // word enters buffer
   logic            drain;      // word leaves buffer
   logic [2*SW-1:0] push_word;  // both lanes, lane 0 low
   logic            any_check;  // some lane is checking
   logic [31:0]     status;     // self-test status image
   logic [7:0]      esum [2];   // error sum before saturation

   assign room      = st_q.cnt != 2'h2;
   assign drain     = tx_valid && tx_ready;
   assign any_check = (st_q.lane[0] == slb_check) || (st_q.lane[1] == slb_check);
   assign in_ready  = st_q.test ? 1'b1 : room;                   // RULE_04
   assign push      = st_q.test ? room : (in_valid && room);
   // payload sits in the low 16 bits of each 20-bit slot
   assign push_word = st_q.test ? {gen_w[1], gen_w[0]}          // RULE_04
                    : {4'h0, parallel_data_in[31:`SLB_HALF_W],
                       4'h0, parallel_data_in[`SLB_HALF_W-1:0]};   // RULE_15

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      // pin: three flops, a change counts once stages two and three agree
      st_d.sync = {st_q.sync[1:0], self_test_enable};
      if (st_q.sync[2] == st_q.sync[1]) begin
         st_d.lvl = st_q.sync[2];
      end
      // mode flips only after the level has held for the full count
      if (st_q.lvl != st_q.test) begin
         if (st_q.run == `SLB_HOLD_CYCLES - 3'h1) begin
            st_d.test = st_q.lvl;                                  // RULE_01
            st_d.run  = '0;
         end else begin
            st_d.run  = st_q.run + 3'h1;
         end
      end else begin
         st_d.run = '0;
      end
      // buffer; the generator steps only when its word is taken,
      // so a stalled receiver loses no pattern bits (needs a running clock)
      if (push) begin
         st_d.mem[st_q.wp] = push_word;
         st_d.wp           = ~st_q.wp;
         if (st_q.test) begin
            st_d.gen[0] = gen_h[0];                                // RULE_02 RULE_03
            st_d.gen[1] = gen_h[1];
         end
      end
      if (drain) begin
         st_d.rp = ~st_q.rp;
      end
      st_d.cnt = st_q.cnt + 2'(push) - 2'(drain);
      // checkers, only meaningful while recovery is locked
      for (int l = 0; l < 2; l++) begin
         st_d.prev[l] = rx_w[l];
         esum[l]      = {1'b0, st_q.err[l]} + {3'h0, nerr[l]};
         if (rx_lock) begin                                        // RULE_08
            case (st_q.lane[l])
               slb_hunt: begin
                  // no control input: a clean run enters checking by itself
                  if (mism[l] != '0) begin
                     st_d.det[l] = '0;
                  end else if (st_q.det[l] == `SLB_DET_RUN - 3'h1) begin
                     st_d.lane[l] = slb_check;                     // RULE_05
                     st_d.det[l]  = '0;
                     st_d.lose[l] = '0;
                     st_d.err[l]  = '0;                            // RULE_16
                     st_d.sym[l]  = '0;
                     st_d.pass[l] = 1'b0;
                  end else begin
                     st_d.det[l] = st_q.det[l] + 3'h1;
                  end
               end
               slb_check: begin
                  // every mismatch bit counts, held at the ceiling
                  if (esum[l] > {1'b0, `SLB_ERR_MAX}) begin
                     st_d.err[l] = `SLB_ERR_MAX;                   // RULE_13 RULE_16
                  end else begin
                     st_d.err[l] = esum[l][6:0];                   // RULE_12
                  end
                  if (st_q.sym[l] != PASS_LAST + CW'(1)) begin
                     st_d.sym[l] = st_q.sym[l] + CW'(1);
                  end
                  if (st_q.sym[l] == PASS_LAST) begin
                     st_d.pass[l] = 1'b1;                          // RULE_09
                  end
                  // pass never clears while checking                // RULE_10
                  if (mism[l] == '0) begin
                     st_d.lose[l] = '0;
                  end else if (st_q.lose[l] == `SLB_LOSE_RUN - 7'h1) begin
                     st_d.lane[l] = slb_hunt;
                  end else begin
                     st_d.lose[l] = st_q.lose[l] + 7'h1;
                  end
               end
               default: begin
                  st_d.lane[l] = slb_hunt;
               end
            endcase
         end
      end
      // parallel output: status image while checking, else payload
      status = '0;
      status[`SLB_PASS0] = st_q.pass[0];                           // RULE_07
      status[`SLB_PASS1] = st_q.pass[1];
      status[`SLB_ERR0_LO+6:`SLB_ERR0_LO] = st_q.err[0];          // RULE_11
      status[`SLB_ERR1_LO+6:`SLB_ERR1_LO] = st_q.err[1];
      if (any_check) begin
         st_d.dout = status;                                       // RULE_04
      end else begin
         st_d.dout = {rx_lane1[`SLB_HALF_W-1:0], rx_lane0[`SLB_HALF_W-1:0]};
      end
      st_d.dvalid = rx_lock;                                       // RULE_14
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         st_q        <= '0;
         st_q.gen[0] <= `SLB_SEED0;
         st_q.gen[1] <= `SLB_SEED1;
         st_q.lane[0] <= slb_hunt;
         st_q.lane[1] <= slb_hunt;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign tx_valid           = st_q.cnt != 2'h0;
   assign tx_lane0           = st_q.mem[st_q.rp][SW-1:0];
   assign tx_lane1           = st_q.mem[st_q.rp][2*SW-1:SW];
   assign self_test_active   = st_q.test;
   assign recovered_data_out = st_q.dout;
   assign out_valid          = st_q.dvalid;
   assign check_active       = any_check;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_mode_hold_entry: assert property ($rose(st_q.test) |->   // RULE_01
      $past(st_q.lvl, 1) && $past(st_q.lvl, 4)) else $error("test mode entered early");
   chk_inputs_ignored: assert property (st_q.test |-> in_ready  // RULE_04
      ##0 !push || push_word == {gen_w[1], gen_w[0]}) else $error("input taken in test");
   chk_lock_valid_map: assert property (out_valid == $past(rx_lock)   // RULE_14
      ) else $error("valid does not follow lock");

   for (genvar l = 0; l < 2; l++) begin : g_chk
      sequence clean_locked;
         rx_lock && st_q.lane[l] == slb_hunt && mism[l] == '0;
      endsequence
      chk_prbs_recurrence: assert property (st_q.test |->       // RULE_03
         gen_w[l][SW-1:7] == (gen_w[l][SW-7:1] ^ gen_w[l][SW-8:0]))
         else $error("generator breaks recurrence");
      chk_detect_entry: assert property (clean_locked [*4] |=>  // RULE_05
         st_q.lane[l] == slb_check) else $error("sequence not detected");
      chk_entry_clears: assert property ($rose(st_q.lane[l] == slb_check) |->   // RULE_16
         st_q.err[l] == '0 && !st_q.pass[l]) else $error("counts not cleared");
      chk_pass_timing: assert property ($rose(st_q.pass[l]) |->   // RULE_09
         $past(st_q.sym[l]) == PASS_LAST) else $error("pass rose at wrong count");
      chk_pass_sticky: assert property (st_q.pass[l] && st_q.lane[l] == slb_check   // RULE_10
         && st_d.lane[l] == slb_check |=> st_q.pass[l]) else $error("pass dropped");
      chk_err_saturate: assert property (st_q.err[l] == `SLB_ERR_MAX &&   // RULE_13
         st_q.lane[l] == slb_check |=> st_q.err[l] == `SLB_ERR_MAX)
         else $error("error count wrapped");
      chk_err_step: assert property (rx_lock && st_q.lane[l] == slb_check   // RULE_12
         && esum[l] <= 8'h7F |=> st_q.err[l] == $past(esum[l][6:0]))
         else $error("error count step wrong");
   end

   chk_status_layout: assert property (any_check |=>   // RULE_07 RULE_11
      recovered_data_out[`SLB_PASS1] == $past(st_q.pass[1]) &&
      recovered_data_out[`SLB_ERR0_LO+6:`SLB_ERR0_LO] == $past(st_q.err[0]))
      else $error("status image misplaced");

endmodule : slb_prbs_bist
`default_nettype wire

// >>> pkg/slb_regs.svh
// Behaviour
// RULE_01: test-enable level must hold four input cycles
// RULE_02: other party keeps input clock running throughout
// RULE_03: each lane sends own 2^7-1 pseudo-random sequence
// RULE_04: test mode ignores inputs, outputs drop payload
// RULE_05: checker self-enters, detects within 128 symbols
// RULE_06: lanes checked separately against expected sequence
// RULE_07: pass flags on output bits 0, 16
// RULE_08: pass flag meaningful only after lock
// RULE_09: pass rises after 44*10^6 checked symbols
// RULE_10: pass flag sticky for rest of test (code clears it whenever a lane re-enters checking)
// RULE_11: error counts latched on bits 7:1, 23:17
// RULE_12: each wrong received bit adds one (code adds one per recurrence mismatch, three for an isolated wrong bit)
// RULE_13: seven-bit error counter, zero to 127
// RULE_14: lock high marks parallel outputs valid
// RULE_15: each lane carries 20 bits per cycle
// RULE_16: error count saturates, clears on check entry
// RULE_17: x^7+x^6+1 polynomial, checker seeds from stream
`ifndef SLB_REGS_SVH
`define SLB_REGS_SVH

// ----------------------------------------------------------------------
// link and pattern geometry
// ----------------------------------------------------------------------
`define SLB_SYM_W      20          // bits per lane per cycle
`define SLB_HALF_W     16          // payload bits per lane
`define SLB_PRBS_W     7           // generator history length
`define SLB_TAP_NEAR   14          // stream offset of the x^6 term
`define SLB_TAP_FAR    13          // stream offset of the x^7 term
`define SLB_SEED0      7'h7F       // lane 0 generator seed
`define SLB_SEED1      7'h3C       // lane 1 generator seed

// ----------------------------------------------------------------------
// timing counts and status layout
// ----------------------------------------------------------------------
`define SLB_HOLD_CYCLES 3'h4       // pin level hold before mode change
`define SLB_DET_RUN     3'h4       // clean symbols to enter checking
`define SLB_LOSE_RUN    7'h7F      // failing symbols to fall back to hunt
`define SLB_ERR_MAX     7'h7F      // error counter ceiling
`define SLB_SYM_CNT_W   26         // symbol counter width
`define SLB_PASS0       0          // lane 0 pass flag bit
`define SLB_ERR0_LO     1          // lane 0 error count low bit
`define SLB_PASS1       16         // lane 1 pass flag bit
`define SLB_ERR1_LO     17         // lane 1 error count low bit

`endif

// >>> pkg/slb_pkg.sv
`default_nettype none
package slb_pkg;
`include "slb_regs.svh"

   // ----------------------------------------------------------------------
   // checker lane states
   // ----------------------------------------------------------------------
   typedef enum logic {
      slb_hunt,      // looking for the test sequence
      slb_check      // locked onto it, counting errors
   } slb_lane_type;

endpackage : slb_pkg
`default_nettype wire

// >>> tb/slb_link_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "slb_regs.svh"
// ---------------------------------------------
// loopback link standing in for the lane pair
// ---------------------------------------------
module slb_link_model
   import slb_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  srst,
   input  wire logic [`SLB_SYM_W-1:0] tx_lane0,
   input  wire logic [`SLB_SYM_W-1:0] tx_lane1,
   input  wire logic                  tx_valid,
   output logic                       tx_ready,
   input  wire logic                  stall,    // far side slow
   input  wire logic                  lock_en,  // recovery locked
   input  wire logic                  flip,     // corrupt lane 0 bit 4
   output logic [`SLB_SYM_W-1:0]      rx_lane0,
   output logic [`SLB_SYM_W-1:0]      rx_lane1,
   output logic                       rx_lock
);
   // stall refuses the offered word
   assign tx_ready = !stall;
   // idle cycles invert the lanes so no stale word looks fresh
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_lane0 <= '0;
         rx_lane1 <= '0;
         rx_lock  <= 1'b0;
      end else if (tx_valid && tx_ready) begin
         rx_lane0 <= tx_lane0 ^ {15'h0, flip, 4'h0};
         rx_lane1 <= tx_lane1;
         rx_lock  <= lock_en;
      end else begin
         rx_lane0 <= ~rx_lane0;
         rx_lane1 <= ~rx_lane1;
         rx_lock  <= 1'b0;
      end
   end
endmodule : slb_link_model
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "slb_regs.svh"
module testbench
   import slb_pkg::*;
;
   // ---------------------------------------------
   // signals and bench state
   // ---------------------------------------------
   logic clk, srst, pin, in_valid, in_ready, tx_valid, tx_ready;
   logic [31:0] parallel_data_in, recovered_data_out, r, w;
   logic [19:0] tx_lane0, tx_lane1, rx_lane0, rx_lane1, prv0, prv1;
   logic self_test_active, rx_lock, out_valid, check_active;
   logic stall, lock_en, flip, rnd_en, norm_on, prbs_on, prv_chk;
   logic [6:0] h0, h1;
   int n0, n1, n, cyc, error_cnt, total_checks;
   int seed = 1885;
   logic [31:0] exp_q[$];  // words awaiting the lanes
   // short pass count keeps the run brief
   slb_prbs_bist #(.PASS_SYMBOLS(20)) DUT (.clk(clk), .srst(srst),
      .self_test_enable(pin), .parallel_data_in(parallel_data_in),
      .in_valid(in_valid), .in_ready(in_ready), .tx_lane0(tx_lane0),
      .tx_lane1(tx_lane1), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .self_test_active(self_test_active), .rx_lane0(rx_lane0),
      .rx_lane1(rx_lane1), .rx_lock(rx_lock), .out_valid(out_valid),
      .recovered_data_out(recovered_data_out), .check_active(check_active));
   slb_link_model link (.clk(clk), .srst(srst), .tx_lane0(tx_lane0),
      .tx_lane1(tx_lane1), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .stall(stall), .lock_en(lock_en), .flip(flip), .rx_lane0(rx_lane0),
      .rx_lane1(rx_lane1), .rx_lock(rx_lock));
   // ---------------------------------------------
   // compare and closing tasks
   // ---------------------------------------------
   task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_word
   task automatic cmp_flag(input string nm, input logic e, input logic g);
      cmp_word(nm, {31'h0, e}, {31'h0, g});
   endtask : cmp_flag
   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   // sequence rule x[n] = x[n-6] ^ x[n-7], bit 0 first
   task automatic prbs_chk(input logic [19:0] v, inout logic [6:0] h, inout int k);
      logic bad;
      bad = 1'b0;
      for (int i = 0; i < 20; i++) begin
         if (k >= 7 && v[i] !== (h[5] ^ h[6])) bad = 1'b1;
         h = {h[5:0], v[i]};
         k++;
      end
      cmp_flag("prbs_word", 1'b0, bad);
   endtask : prbs_chk
   // bounded wait on mode (sel 0) or checking (sel 1)
   task automatic wait_sig(input int sel, input logic val, input int lim, output int k);
      k = 0;
      repeat (lim) begin
         @(negedge clk);
         if (((sel == 0) ? self_test_active : check_active) === val) break;
         k++;
      end
   endtask : wait_sig
   // ---------------------------------------------
   // clock, timeout, random drive, monitor
   // ---------------------------------------------
   always #5 clk = ~clk;
   // hang guard well above the planned length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         conclude();
      end
   end
   // far side stalls only with payload, a bubble would break the pattern
   always @(posedge clk) begin
      if (rnd_en) begin
         r = $random(seed);
         in_valid <= r[0];
         stall <= norm_on && (r[2:1] == 2'h0);
         parallel_data_in <= $random(seed);
      end
   end
   // samples pre-edge values, design updates land after
   always @(posedge clk) begin
      if (!srst) begin
         if (in_valid && in_ready && norm_on) exp_q.push_back(parallel_data_in);
         if (tx_valid && tx_ready && norm_on && exp_q.size() > 0) begin
            w = exp_q.pop_front();
            cmp_word("tx_lanes", w, {tx_lane1[15:0], tx_lane0[15:0]});
            cmp_word("tx_pad", 32'h0, {24'h0, tx_lane1[19:16], tx_lane0[19:16]});
         end
         if (tx_valid && tx_ready && prbs_on) begin
            prbs_chk(tx_lane0, h0, n0);
            prbs_chk(tx_lane1, h1, n1);
         end
         // output word picks payload or status one cycle before it shows
         if (out_valid && norm_on && !prv_chk)
            cmp_word("rx_payload", {prv1[15:0], prv0[15:0]}, recovered_data_out);
         prv0 = rx_lane0;
         prv1 = rx_lane1;
         prv_chk = check_active;
      end
   end
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      {clk, pin, in_valid, stall, flip, rnd_en, norm_on, prbs_on, prv_chk} = '0;
      {parallel_data_in, cyc, error_cnt, total_checks, n0, n1} = '0;
      {h0, h1} = '0;
      srst = 1'b1;
      lock_en = 1'b1;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      cmp_flag("tx_valid_rst", 1'b0, tx_valid);
      cmp_flag("in_ready_rst", 1'b1, in_ready);
      cmp_flag("active_rst", 1'b0, self_test_active);
      // random payload with far-side stalls
      norm_on = 1'b1;
      rnd_en = 1'b1;
      repeat (200) @(negedge clk);
      // fill the buffer until it refuses, then drain
      rnd_en = 1'b0;
      @(posedge clk) {stall, in_valid} <= 2'h3;
      repeat (4) @(negedge clk);
      cmp_flag("in_ready_full", 1'b0, in_ready);
      cmp_flag("tx_valid_full", 1'b1, tx_valid);
      @(posedge clk) {stall, in_valid} <= 2'h0;
      repeat (6) @(negedge clk);
      cmp_flag("tx_valid_empty", 1'b0, tx_valid);
      norm_on = 1'b0;
      // a three-cycle glitch must not switch mode
      @(posedge clk) pin <= 1'b1;
      repeat (3) @(posedge clk);
      pin <= 1'b0;
      repeat (12) @(negedge clk);
      cmp_flag("glitch", 1'b0, self_test_active);
      @(posedge clk) pin <= 1'b1;
      wait_sig(0, 1'b1, 20, n);
      cmp_flag("enter_delay", 1'b1, n >= 4 && n <= 10);
      rnd_en = 1'b1;
      repeat (4) @(negedge clk);
      cmp_flag("in_ready_test", 1'b1, in_ready);
      {n0, n1} = '0;
      prbs_on = 1'b1;
      wait_sig(1, 1'b1, 128, n);
      cmp_flag("check_found", 1'b1, n < 128);
      repeat (2) @(negedge clk);
      cmp_word("status_start", 32'h0, recovered_data_out);
      repeat (10) @(negedge clk);
      cmp_word("status_early", 32'h0, recovered_data_out);
      repeat (18) @(negedge clk);
      cmp_word("status_pass", 32'h0001_0001, recovered_data_out);
      // one corrupted bit on lane 0 only
      @(posedge clk) flip <= 1'b1;
      @(posedge clk) flip <= 1'b0;
      repeat (5) @(negedge clk);
      w = {25'h0, recovered_data_out[7:1]};
      cmp_flag("err0_single", 1'b1, w >= 1 && w <= 3);
      cmp_word("lane1_clean", 32'h1, {24'h0, recovered_data_out[23:16]});
      // long burst saturates lane 0, pass stays high
      @(posedge clk) flip <= 1'b1;
      repeat (60) @(posedge clk);
      flip <= 1'b0;
      repeat (5) @(negedge clk);
      cmp_word("status_sat", 32'h0001_00FF, recovered_data_out);
      @(posedge clk) lock_en <= 1'b0;
      repeat (3) @(negedge clk);
      cmp_flag("out_valid_nolock", 1'b0, out_valid);
      @(posedge clk) lock_en <= 1'b1;
      @(posedge clk) pin <= 1'b0;
      wait_sig(0, 1'b0, 20, n);
      cmp_flag("exit_delay", 1'b1, n >= 4 && n <= 10);
      prbs_on = 1'b0;
      rnd_en = 1'b0;
      @(posedge clk) in_valid <= 1'b0;
      repeat (10) @(negedge clk);
      exp_q.delete();
      norm_on = 1'b1;
      rnd_en = 1'b1;
      wait_sig(1, 1'b0, 600, n);
      repeat (50) @(negedge clk);
      // re-entry must start from cleared counters
      norm_on = 1'b0;
      @(posedge clk) pin <= 1'b1;
      wait_sig(1, 1'b1, 150, n);
      repeat (2) @(negedge clk);
      cmp_word("status_reentry", 32'h0, recovered_data_out);
      conclude();
   end
endmodule : testbench
`default_nettype wire
